// >>> hdl/reset_and_test_strap_control.sv
// reset and test strap control: holds pins safe during reset, sequences release,
// samples the test straps and hands pin drive to the functional logic.
// assumes pins are resolved outside from out/oe_n; functional logic supplies
// the values it wants on each pin once configuration is running.
`timescale 1ns/1ps
module reset_and_test_strap_control
  import reset_strap_pkg::*;
#(
  // cycles from the start pulse to the strap sample; default is 1.5 us at 100 MHz
  parameter int STRAP_WAIT_CYCLES = STRAP_DELAY_CYCLES
)
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic mirror_park_request_low_i,
  input wire logic [STRAP_PINS-1:0] test_strap_pin_i,
  output logic [STRAP_PINS-1:0] test_strap_pin_o,
  output logic [STRAP_PINS-1:0] test_strap_pin_oe_n_o,
  input wire logic [STRAP_PINS-1:0] strap_func_out_i,
  input wire flash_pins_t flash_func_i,
  output flash_pins_t flash_o,
  output logic flash_oe_n_o,
  input wire gp_pins_drive_t gp_func_i,
  output gp_pins_drive_t gp_o,
  input wire light_pins_t light_func_i,
  output light_pins_t light_o,
  output logic config_start_o,
  output logic config_running_o,
  output logic straps_valid_o,
  output logic [STRAP_PINS-1:0] test_mode_select_o,
  output logic park_released_o
);

  logic rst_sync_n;
  seq_state_t state_reg;
  logic [STRAP_CNT_W-1:0] delay_cnt_reg;
  logic [STRAP_PINS-1:0] strap_meta_reg;
  logic [STRAP_PINS-1:0] strap_sync_reg;
  wire logic [STRAP_PINS-1:0] test_mode_bits;
  logic straps_valid_reg;
  logic start_reg;
  logic park_meta_reg;
  logic park_sync_reg;
  wire logic [STRAP_PINS-1:0] strap_out_bits;
  flash_pins_t flash_reg;
  logic flash_live_reg;
  gp_pins_drive_t gp_reg;
  light_pins_t light_reg;
  logic running;
  logic sample_now;

  // end value of the strap wait, cut to the counter's width on purpose
  localparam logic [STRAP_CNT_W-1:0] WAIT_LAST = STRAP_CNT_W'(STRAP_WAIT_CYCLES - 1);

  // reset input is active low; release is synchronised before anything starts
  reset_release_sync u_reset_release_sync (
    .clk_i(clk_i),
    .power_on_reset_low_i(rst_n_i),
    .rst_sync_n_o(rst_sync_n)
  );

  assign running = (state_reg == SEQ_RUN);
  assign sample_now = (state_reg == SEQ_WAIT_STRAP) && (delay_cnt_reg == WAIT_LAST);

  // strap pins come from outside the clock domain; the level taken at the end of
  // the wait is the pin as it stood two cycles earlier
  always_ff @(posedge clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      strap_meta_reg <= '0;
      strap_sync_reg <= '0;
    end else begin
      strap_meta_reg <= test_strap_pin_i;
      strap_sync_reg <= strap_meta_reg;
    end
  end

  // park is a pin level too and gets the same two flops
  always_ff @(posedge clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      park_meta_reg <= 1'b0;
      park_sync_reg <= 1'b0;
    end else begin
      park_meta_reg <= mirror_park_request_low_i;
      park_sync_reg <= park_meta_reg;
    end
  end

  // sequencer: start only once the synchronised release has been seen
  // hold lasts one cycle so the start pulse comes from a settled state
  always_ff @(posedge clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_reg <= SEQ_HOLD;
      delay_cnt_reg <= '0;
    end else begin
      case (state_reg)
        SEQ_HOLD: begin
          state_reg <= SEQ_WAIT_STRAP;
          delay_cnt_reg <= '0;
        end
        SEQ_WAIT_STRAP: begin
          // wait about 1.5 us from release before sampling
          // the count stops at its end value; leaving the state makes the sample one-shot
          if (delay_cnt_reg == WAIT_LAST) begin
            state_reg <= SEQ_RUN;
          end else begin
            delay_cnt_reg <= delay_cnt_reg + 1'b1;
          end
        end
        SEQ_RUN: begin
          state_reg <= SEQ_RUN;
        end
        default: begin
          state_reg <= SEQ_HOLD;
        end
      endcase
    end
  end

  // one-cycle pulse marking the start of self-configuration
  always_ff @(posedge clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      start_reg <= 1'b0;
    end else begin
      start_reg <= (state_reg == SEQ_HOLD);
    end
  end

  // single sample of the straps; the flag also hands the strap pins over
  always_ff @(posedge clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      straps_valid_reg <= 1'b0;
    end else if (sample_now) begin
      straps_valid_reg <= 1'b1;
    end
  end

  // per pin: one sample flop and one drive flop; pin i only ever feeds select bit i,
  // so the pairing cannot be crossed when the pin count changes
  for (genvar i = 0; i < STRAP_PINS; i++) begin : g_strap
    logic mode_bit_reg;
    logic out_bit_reg;

    // held until the next reset
    always_ff @(posedge clk_i or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        mode_bit_reg <= TEST_MODE_RESET[i];
      end else if (sample_now) begin
        mode_bit_reg <= strap_sync_reg[i];
      end
    end

    // released to high impedance during reset, driven once sampled
    always_ff @(posedge clk_i or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        out_bit_reg <= 1'b0;
      end else begin
        out_bit_reg <= straps_valid_reg ? strap_func_out_i[i] : 1'b0;
      end
    end

    assign test_mode_bits[i] = mode_bit_reg;
    assign strap_out_bits[i] = out_bit_reg;
  end

  // flash pins stay inactive until configuration runs; oe tied to run state
  always_ff @(posedge clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      flash_reg <= '0;
    end else if (running) begin
      flash_reg <= flash_func_i;
    end
  end

  // chip-select bits reset low, so the pins are enabled only once the first
  // functional value has landed; enabling with running would select the flash
  // for one cycle with whatever the reset value holds
  always_ff @(posedge clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      flash_live_reg <= 1'b0;
    end else begin
      flash_live_reg <= running;
    end
  end

  // gp pins: all undriven in reset; afterwards the functional logic may make
  // unused ones outputs so their inputs do not float
  always_ff @(posedge clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      gp_reg.out <= '0;
      gp_reg.oe_n <= '1;
    end else if (running) begin
      gp_reg <= gp_func_i;
    end
  end

  // light selects and mirror drive enable forced low through reset
  always_ff @(posedge clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      light_reg <= '0;
    end else begin
      light_reg <= running ? light_func_i : '0;
    end
  end

  // pin enables are gated with the raw reset too, so they float the instant reset
  // asserts; the synchronised reset also clears their flops at once
  assign test_strap_pin_oe_n_o = (straps_valid_reg && rst_n_i) ? '0 : '1;
  assign test_strap_pin_o = strap_out_bits;
  assign flash_oe_n_o = !(flash_live_reg && rst_n_i);
  assign flash_o = flash_reg;
  assign gp_o.out = gp_reg.out;
  assign gp_o.oe_n = rst_n_i ? gp_reg.oe_n : '1;
  assign light_o = rst_n_i ? light_reg : '0;

  assign config_start_o = start_reg;
  assign config_running_o = running;
  assign straps_valid_o = straps_valid_reg;
  assign test_mode_select_o = test_mode_bits;
  // the 500 ms quiet period is the host's job; this only reports park release
  assign park_released_o = park_sync_reg && running;

endmodule : reset_and_test_strap_control

// >>> hdl/reset_release_sync.sv
// two-stage reset release synchroniser.
// assumes the input reset is asynchronous to clk_i; assertion acts at once.
`timescale 1ns/1ps
module reset_release_sync
  import reset_strap_pkg::*;
(
  input wire logic clk_i,
  input wire logic power_on_reset_low_i,
  output logic rst_sync_n_o
);

  logic [RESET_SYNC_STAGES-1:0] sync_reg;

  // assert asynchronously, release only after the stages clock in ones
  always_ff @(posedge clk_i or negedge power_on_reset_low_i) begin
    if (!power_on_reset_low_i) begin
      sync_reg <= '0;
    end else begin
      sync_reg <= {sync_reg[RESET_SYNC_STAGES-2:0], 1'b1};
    end
  end

  assign rst_sync_n_o = sync_reg[RESET_SYNC_STAGES-1];

endmodule : reset_release_sync

// >>> hdl/reset_strap_pkg.sv
// package for the reset and test strap control block: timing constants, strap layout,
// pin carrier types.
// assumes a single 100 MHz clock and no software-visible registers.
//
// Functional notes
// - reset input is active low; self-configuration starts on its rising edge only.
// - flash serial pins and all general-purpose pins stay high impedance during reset.
// - light-source selects and mirror drive enable forced low during reset.
// - no output is in its active state while reset is held; flash_o holds both active-low chip-select bits low, with flash_oe_n_o high.
// - test strap pins stay high impedance, weakly pulled down, during reset.
// - about 1.5 us after release, sample each strap once, then drive it.
// - strap pin 0 feeds select bit 0, strap pin 1 feeds bit 1.
// - after release, unused two-way pins may be configured as outputs.
package reset_strap_pkg;

  localparam int CLK_PERIOD_PS = 10000;
  localparam int STRAP_DELAY_NS_X10 = 15;
  // 1.5 us as a rounded-down count of clock cycles, never below one
  localparam int STRAP_DELAY_CYCLES_RAW = (STRAP_DELAY_NS_X10 * 100000) / CLK_PERIOD_PS;
  localparam int STRAP_DELAY_CYCLES = (STRAP_DELAY_CYCLES_RAW < 1) ? 1 : STRAP_DELAY_CYCLES_RAW;
  localparam int STRAP_CNT_W = 8;
  localparam logic [STRAP_CNT_W-1:0] STRAP_CNT_LAST = STRAP_CNT_W'(STRAP_DELAY_CYCLES - 1);

  localparam int STRAP_PINS = 2;
  localparam int STRAP_BIT_0 = 0;
  localparam int STRAP_BIT_1 = 1;
  localparam int GP_PINS = 20;
  localparam int RESET_SYNC_STAGES = 2;
  localparam logic [STRAP_PINS-1:0] TEST_MODE_RESET = 2'h0;

  typedef enum logic [1:0] {
    SEQ_HOLD,
    SEQ_WAIT_STRAP,
    SEQ_RUN
  } seq_state_t;

  // two-signal view of a group of two-way pins; oe low means driving
  typedef struct packed {
    logic [GP_PINS-1:0] out;
    logic [GP_PINS-1:0] oe_n;
  } gp_pins_drive_t;

  typedef struct packed {
    logic clk;
    logic dout;
    logic sel_0_low;
    logic sel_1_low;
  } flash_pins_t;

  typedef struct packed {
    logic light_0;
    logic light_1;
    logic drive_enable;
  } light_pins_t;

endpackage : reset_strap_pkg

// >>> test/strap_board_model.sv
// board side of the strap pins: optional pull-up, else the weak pull-down wins
// assumes the device drives when oe_n is low
`timescale 1ns/1ps
module strap_board_model
  import reset_strap_pkg::*;
(
  input wire logic [STRAP_PINS-1:0] pull_high_i,
  input wire logic [STRAP_PINS-1:0] out_i,
  input wire logic [STRAP_PINS-1:0] oe_n_i,
  output logic [STRAP_PINS-1:0] level_o
);
  // a pull-up only ever picks a test mode, never normal use
  assign level_o = (~oe_n_i & out_i) | (oe_n_i & pull_high_i);
endmodule : strap_board_model

// >>> test/strap_ctl_asserts.sv
// checker for the reset and strap control block, bound to its ports
// assumes one clock; reset-time checks run with no disable on purpose
`timescale 1ns/1ps
module strap_ctl_asserts
  import reset_strap_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [STRAP_PINS-1:0] test_strap_pin_oe_n_o,
  input wire logic flash_oe_n_o,
  input wire gp_pins_drive_t gp_o,
  input wire light_pins_t light_o,
  input wire logic config_start_o,
  input wire logic config_running_o,
  input wire logic straps_valid_o,
  input wire logic [STRAP_PINS-1:0] test_mode_select_o
);
  property p_float;
    @(posedge clk_i) !rst_n_i |-> (&gp_o.oe_n) && flash_oe_n_o && (&test_strap_pin_oe_n_o);
  endproperty
  a_float: assert property (p_float) else $error("pins driven in reset");
  property p_light;
    @(posedge clk_i) !rst_n_i |-> light_o == 3'h0;
  endproperty
  a_light: assert property (p_light) else $error("light high in reset");
  property p_idle;
    @(posedge clk_i) !rst_n_i |-> !(config_start_o || config_running_o || straps_valid_o);
  endproperty
  a_idle: assert property (p_idle) else $error("status active in reset");
  property p_start;
    @(posedge clk_i) disable iff (!rst_n_i) $rose(rst_n_i) |-> ##[1:5] config_start_o;
  endproperty
  a_start: assert property (p_start) else $error("no start after release");
  property p_pulse;
    @(posedge clk_i) disable iff (!rst_n_i) config_start_o |=> !config_start_o;
  endproperty
  a_pulse: assert property (p_pulse) else $error("start longer than a cycle");
  property p_delay;
    @(posedge clk_i) disable iff (!rst_n_i)
      config_start_o |-> ##140 !straps_valid_o ##[1:20] straps_valid_o;
  endproperty
  a_delay: assert property (p_delay) else $error("strap sample off time");
  property p_drive;
    @(posedge clk_i) disable iff (!rst_n_i)
      $rose(straps_valid_o) |-> test_strap_pin_oe_n_o == 2'h0 && config_running_o;
  endproperty
  a_drive: assert property (p_drive) else $error("straps not driven");
  property p_hold;
    @(posedge clk_i) disable iff (!rst_n_i) $past(straps_valid_o) |-> $stable(test_mode_select_o);
  endproperty
  a_hold: assert property (p_hold) else $error("select resampled");
  property p_flash;
    @(posedge clk_i) disable iff (!rst_n_i) config_running_o |=> !flash_oe_n_o;
  endproperty
  a_flash: assert property (p_flash) else $error("flash not driven");
endmodule : strap_ctl_asserts

bind reset_and_test_strap_control strap_ctl_asserts u_chk (.clk_i, .rst_n_i,
  .test_strap_pin_oe_n_o, .flash_oe_n_o, .gp_o, .light_o, .config_start_o,
  .config_running_o, .straps_valid_o, .test_mode_select_o);

// >>> test/tb_top.sv
// bench for the reset and strap control block: four strap codes, reset each time
// assumes the checker is bound and the board model resolves the strap pins
`timescale 1ns/1ps
module tb_top;
  import reset_strap_pkg::*;
  logic clk_i = 0, rst_n_i = 1, park_low = 1, flash_oe_n, start, running, valid, park_rel;
  logic [STRAP_PINS-1:0] pull_hi = '0, strap_func = '0, strap_out, strap_oe_n, lvl, sel;
  flash_pins_t flash_func = '0, flash_o;
  gp_pins_drive_t gp_func = '0, gp_o;
  light_pins_t light_func = '0, light_o;
  int mismatches = 0, checks_done = 0, cyc = 0, n, exp_sel;
  int exp_q[$];
  logic [15:0] lfsr = 16'h0032;
  initial forever #5 clk_i = ~clk_i;
  strap_board_model board (.pull_high_i(pull_hi), .out_i(strap_out), .oe_n_i(strap_oe_n),
    .level_o(lvl));
  reset_and_test_strap_control DUT (.clk_i, .rst_n_i, .mirror_park_request_low_i(park_low),
    .test_strap_pin_i(lvl), .test_strap_pin_o(strap_out), .test_strap_pin_oe_n_o(strap_oe_n),
    .strap_func_out_i(strap_func), .flash_func_i(flash_func), .flash_o,
    .flash_oe_n_o(flash_oe_n), .gp_func_i(gp_func), .gp_o, .light_func_i(light_func), .light_o,
    .config_start_o(start), .config_running_o(running), .straps_valid_o(valid),
    .test_mode_select_o(sel), .park_released_o(park_rel));
  function automatic logic [15:0] next_rand(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : next_rand
  task automatic chk(input logic ok, input string what);
    checks_done++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("BAD %0t %s", $time, what);
    end
  endtask : chk
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict
  // run is about 720 cycles; the ceiling leaves ample slack
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      give_verdict();
    end
  end
  initial begin
    // a clean falling edge at time zero resets the design before the first clock
    rst_n_i <= 1'b0;
    for (int code = 0; code < 4; code++) begin
      @(posedge clk_i);
      repeat (3) lfsr = next_rand(lfsr);
      rst_n_i <= 1'b0;
      pull_hi <= code[1:0];
      gp_func <= {lfsr, lfsr[11:0], lfsr[15:4]};
      flash_func <= lfsr[3:0];
      light_func <= lfsr[6:4];
      strap_func <= lfsr[8:7];
      park_low <= lfsr[9];
      // model: a pin held high at sampling sets its own select bit only
      exp_sel = 0;
      for (int i = 0; i < STRAP_PINS; i++) begin
        if (code[i]) exp_sel += 1 << i;
      end
      exp_q.push_back(exp_sel);
      repeat (20) @(posedge clk_i);
      #1 chk((&gp_o.oe_n) && flash_oe_n && (&strap_oe_n), "float");
      chk(light_o === 3'h0, "light");
      chk({start, running, valid, park_rel, sel} === 6'h00, "idle");
      @(posedge clk_i);
      rst_n_i <= 1'b1; // clock and inputs settled for 20 cycles first
      for (n = 0; start !== 1'b1 && n < 10; n++) @(posedge clk_i) #1;
      chk(n > 0 && n < 6, "start");
      for (n = 0; valid !== 1'b1 && n < 300; n++) @(posedge clk_i) #1;
      chk(n >= STRAP_DELAY_CYCLES - 2 && n <= STRAP_DELAY_CYCLES + 4, "delay");
      exp_sel = exp_q.pop_front();
      chk(sel === exp_sel[1:0] && strap_oe_n === 2'h0 && running === 1'b1, "sample");
      @(posedge clk_i);
      pull_hi <= ~code[1:0];
      repeat (4) @(posedge clk_i);
      #1 chk(sel === exp_sel[1:0], "resample");
      chk(gp_o === gp_func && flash_o === flash_func && light_o === light_func, "func");
      chk(!flash_oe_n && strap_out === strap_func && park_rel === park_low, "drive");
      $display("test %0d done", code);
    end
    give_verdict();
  end
endmodule : tb_top
